// ### include/pwm14_pkg.sv
package pwm14_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W   = 16;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned COARSE_W = 8;
  localparam int unsigned FINE_W   = 6;
  localparam int unsigned COUNT_W  = 8;
  localparam int unsigned FRAME_W  = 6;

  // ---------------------------------------------------------------
  // Register addresses on the CPU bus
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] RATE_MULT_ADDR   = 16'h0035;
  localparam logic [ADDR_W-1:0] COARSE_DUTY_ADDR = 16'h0036;

  // ---------------------------------------------------------------
  // Reset values and timing
  // ---------------------------------------------------------------
  localparam logic [COARSE_W-1:0] COARSE_RESET = 8'h00;
  localparam logic [FINE_W-1:0]   FINE_RESET   = 6'h00;
  localparam logic [DATA_W-1:0]   READ_ZERO    = 8'h00;
  localparam logic [COUNT_W-1:0]  COUNT_RESET  = 8'h00;
  localparam logic [FRAME_W-1:0]  FRAME_RESET  = 6'h00;
  // 256 clocks per modulation cycle, 64 cycles per frame
  localparam logic [COUNT_W-1:0]  CYCLE_LAST   = 8'hFF;
  localparam logic [FRAME_W-1:0]  FRAME_LAST   = 6'h3F;
  localparam logic [COUNT_W-1:0]  COUNT_STEP   = 8'h01;
  localparam logic [FRAME_W-1:0]  FRAME_STEP   = 6'h01;
  localparam logic [FRAME_W-1:0]  FRAME_ONE    = 6'h01;

endpackage : pwm14_pkg

// ### include/pwm14_if.sv
`timescale 1ns/100ps

// Shared timing and fine-value signals between the channel pieces
interface pwm14_if;
  import pwm14_pkg::*;

  logic [COUNT_W-1:0] cycle_count;
  logic               cycle_end;
  logic [FRAME_W-1:0] frame_index;
  logic [FINE_W-1:0]  fine_active;
  logic               fine_pulse;

  modport timer   (output cycle_count, output cycle_end, output frame_index);
  modport decoder (input frame_index, input cycle_end, input fine_active, output fine_pulse);
  modport ctrl    (input cycle_count, input cycle_end, input fine_pulse, output fine_active);
endinterface : pwm14_if

// ### core/modulation_timer.sv
`timescale 1ns/100ps

module modulation_timer
  import pwm14_pkg::*;
(
  input  wire logic clk_sys_i,
  input  wire logic rstn_i,
  pwm14_if.timer    tim
);

  // ---------------------------------------------------------------
  // Clock position within the 256-clock modulation cycle
  // ---------------------------------------------------------------
  logic [COUNT_W-1:0] count;
  logic [FRAME_W-1:0] frame;

  // RL3 cycle counter wraps
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count <= COUNT_RESET;
    end else begin
      count <= count + COUNT_STEP; // Natural wrap at 8 bits restarts each cycle
    end
  end

  // RL11 frame counter advances per cycle
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      frame <= FRAME_RESET;
    end else if (count == CYCLE_LAST) begin
      frame <= frame + FRAME_STEP; // Wraps continuously at 64
    end
  end

  // Timing outputs
  assign tim.cycle_count = count;
  assign tim.cycle_end   = (count == CYCLE_LAST);
  assign tim.frame_index = frame;

endmodule : modulation_timer

// ### core/rate_mult_decoder.sv
`timescale 1ns/100ps

module rate_mult_decoder
  import pwm14_pkg::*;
(
  pwm14_if.decoder dec
);

  // ---------------------------------------------------------------
  // Slot selection: bit k owns cycles whose low 6-k bits equal 2^(5-k)
  // ---------------------------------------------------------------
  logic [FINE_W-1:0] slot_hit;

  // RL5 frame slot decode
  for (genvar k = 0; k < FINE_W; k++) begin : g_slot
    localparam logic [FRAME_W-1:0] PATT = FRAME_ONE << (FINE_W - 1 - k);
    localparam logic [FRAME_W-1:0] MASK = (FRAME_ONE << (FINE_W - k)) - FRAME_ONE;
    assign slot_hit[k] = ((dec.frame_index & MASK) == PATT);
  end

  // RL4 one-clock pulse at cycle end
  // Slots never overlap, so at most one pulse lands in any cycle
  assign dec.fine_pulse = dec.cycle_end & (|(dec.fine_active & slot_hit));

endmodule : rate_mult_decoder

// ### core/fourteen_bit_pwm_rate_mult.sv
`timescale 1ns/100ps

// Behaviour
// RL1 - Output is the OR of coarse waveform and multiplier pulses, CPU clocked.
// RL2 - Coarse high for M clocks per cycle; zero low, 255 gives 255/256.
// RL3 - Modulation cycle is 256 clocks, coarse count restarts each cycle.
// RL4 - Multiplier value N inserts N one-clock pulses across 64 cycles.
// RL5 - Bit k of N owns fixed evenly spaced cycles in the frame.
// RL6 - Average duty is (M + N/64)/256, repeating every 64 cycles.
// RL7 - Writing the multiplier address only loads a holding buffer.
// RL8 - Coarse write moves both values to active at next cycle start.
// RL9 - Software writes multiplier first, then coarse, to avoid glitches.
// RL10 - Fine value in bits 5..0, coarse holds high byte; both reset zero.
// RL11 - Multiplier bits 7..6 read zero; frame counter advances each cycle.
module fourteen_bit_pwm_rate_mult
  import pwm14_pkg::*;
(
  input  wire logic              clk_sys_i,
  input  wire logic              rstn_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              wr_en_i,
  input  wire logic              rd_en_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  output logic      [DATA_W-1:0] rdata_o,
  output logic                   pwm_o,
  output logic                   pwm_pad_oe_o
);

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] reg_addr);
    addr_hit = (a == reg_addr);
  endfunction : addr_hit

  logic wr_fine;
  logic wr_coarse;

  // Write strobes per register
  assign wr_fine   = wr_en_i & addr_hit(addr_i, RATE_MULT_ADDR);
  assign wr_coarse = wr_en_i & addr_hit(addr_i, COARSE_DUTY_ADDR);

  // ---------------------------------------------------------------
  // Channel pieces
  // ---------------------------------------------------------------
  pwm14_if chan ();

  modulation_timer u_timer (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .tim       (chan.timer)
  );

  rate_mult_decoder u_decoder (
    .dec (chan.decoder)
  );

  // ---------------------------------------------------------------
  // Software-visible registers
  // ---------------------------------------------------------------
  logic [FINE_W-1:0]   rate_multiplier;    // Holding buffer for fine value
  logic [COARSE_W-1:0] coarse_duty;        // Last coarse value written
  logic [FINE_W-1:0]   staged_fine;        // Fine value captured with coarse write
  logic [FINE_W-1:0]   fine_active;
  logic [COARSE_W-1:0] coarse_active;

  // RL7 buffer only, output untouched
  // RL10 fine field bits 5..0
  // RL11 upper bits ignored
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rate_multiplier <= FINE_RESET;
    end else if (wr_fine) begin
      rate_multiplier <= wdata_i[FINE_W-1:0];
    end
  end

  // RL8 capture full pair together
  // Pairing the buffer here is what makes the write order matter
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      coarse_duty <= COARSE_RESET;
      staged_fine <= FINE_RESET;
    end else if (wr_coarse) begin
      coarse_duty <= wdata_i;
      staged_fine <= rate_multiplier;
    end
  end

  // RL8 apply at cycle start
  // A write on the boundary clock lands one cycle later, never half applied
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      coarse_active <= COARSE_RESET;
      fine_active   <= FINE_RESET;
    end else if (chan.cycle_end) begin
      coarse_active <= coarse_duty;
      fine_active   <= staged_fine;
    end
  end

  assign chan.fine_active = fine_active;

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  // RL11 unused bits read zero
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= READ_ZERO;
    end else if (rd_en_i) begin
      if (addr_hit(addr_i, RATE_MULT_ADDR)) begin
        rdata_o <= {{(DATA_W-FINE_W){1'b0}}, rate_multiplier};
      end else if (addr_hit(addr_i, COARSE_DUTY_ADDR)) begin
        rdata_o <= coarse_duty;
      end else begin
        rdata_o <= READ_ZERO; // Unmapped reads give zero
      end
    end
  end

  // ---------------------------------------------------------------
  // Output waveform
  // ---------------------------------------------------------------
  logic coarse_level;

  // RL2 high for M clocks
  // Strict compare means 255 tops out at 255/256; only a fine pulse fills the last clock
  assign coarse_level = (chan.cycle_count < coarse_active);

  // RL1 OR of both waveforms
  // RL6 average duty follows
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pwm_o        <= 1'b0;
      pwm_pad_oe_o <= 1'b1;
    end else begin
      pwm_o        <= coarse_level | chan.fine_pulse;
      pwm_pad_oe_o <= ~(coarse_level | chan.fine_pulse); // Open drain pulls low while output low
    end
  end

endmodule : fourteen_bit_pwm_rate_mult

// ### sim/fourteen_bit_pwm_rate_mult_properties.sv
`timescale 1ns/100ps
module pwm14_checker
  import pwm14_pkg::*;
(
  input wire logic              clk_sys_i,
  input wire logic              rstn_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic              wr_en_i,
  input wire logic              rd_en_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic              pwm_o,
  input wire logic              pwm_pad_oe_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  logic [7:0] cw;
  logic [8:0] st;
  logic [8:0] lo;
  // ------
  // Helpers
  // ------
  // Last coarse write and clocks since it; 511 is past any load boundary
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cw <= 8'h00;
      st <= 9'h000;
    end else if (wr_en_i && addr_i == COARSE_DUTY_ADDR) begin
      cw <= wdata_i;
      st <= 9'h000;
    end else if (st != 9'h1FF) begin
      st <= st + 9'h001;
    end
  end
  // Low-run length, saturating so it cannot wrap into a false pass
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) lo <= 9'h000;
    else if (pwm_o) lo <= 9'h000;
    else if (lo != 9'h1FF) lo <= lo + 9'h001;
  end
  // ------
  // Assertions
  // ------
  a_oe_inverse: assert property (pwm_pad_oe_o == !pwm_o) else $error("pad enable wrong");
  a_reset_quiet: assert property ($rose(rstn_i) |-> !pwm_o && rdata_o == READ_ZERO) else $error("reset out");
  a_unmapped_zero: assert property (rd_en_i && addr_i != RATE_MULT_ADDR && addr_i != COARSE_DUTY_ADDR
    |=> rdata_o == READ_ZERO) else $error("unmapped read");
  a_rate_upper: assert property (rd_en_i && addr_i == RATE_MULT_ADDR |=> rdata_o[7:6] == 2'b00)
    else $error("upper bits");
  a_rdata_hold: assert property (!rd_en_i |=> $stable(rdata_o)) else $error("rdata moved");
  a_rate_back: assert property (wr_en_i && addr_i == RATE_MULT_ADDR ##1 rd_en_i && !wr_en_i
    && addr_i == RATE_MULT_ADDR |=> rdata_o == {2'b00, $past(wdata_i[5:0], 2)}) else $error("buffer");
  a_coarse_back: assert property (wr_en_i && addr_i == COARSE_DUTY_ADDR ##1 rd_en_i && !wr_en_i
    && addr_i == COARSE_DUTY_ADDR |=> rdata_o == $past(wdata_i, 2)) else $error("coarse");
  a_low_run: assert property (st == 9'h1FF && cw != 8'h00 |-> lo <= 9'h100 - {1'b0, cw})
    else $error("low run");
  c_rate_back: cover property (wr_en_i && addr_i == RATE_MULT_ADDR ##1 rd_en_i);
  c_full_duty: cover property (st == 9'h1FF && cw == 8'hFF);
  c_unmapped: cover property (rd_en_i && addr_i == 16'h0037);
endmodule : pwm14_checker

bind fourteen_bit_pwm_rate_mult pwm14_checker u_chk (.clk_sys_i, .rstn_i, .addr_i, .wr_en_i, .rd_en_i,
  .wdata_i, .rdata_o, .pwm_o, .pwm_pad_oe_o);

// ### sim/fourteen_bit_pwm_rate_mult_tb.sv
`timescale 1ns/100ps
module fourteen_bit_pwm_rate_mult_tb;
  import pwm14_pkg::*;
  logic              clk_sys_i, rstn_i, wr_en_i, rd_en_i;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i, rdata_o;
  logic              pwm_o, pwm_pad_oe_o;
  logic [15:0]       q[$], duty;
  logic [31:0]       seed;
  logic [13:0]       tick;
  int                bad_count, total_checks;

  fourteen_bit_pwm_rate_mult u_dut (.clk_sys_i, .rstn_i, .addr_i, .wr_en_i, .rd_en_i,
    .wdata_i, .rdata_o, .pwm_o, .pwm_pad_oe_o);

  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Frame cycles owned by each multiplier bit, taken from the slot table
  function automatic logic in_slot(input logic [5:0] n, input logic [5:0] f);
    return (n[0] && f == 6'h20) || (n[1] && f[4:0] == 5'h10) || (n[2] && f[3:0] == 4'h8)
      || (n[3] && f[2:0] == 3'h4) || (n[4] && f[1:0] == 2'h2) || (n[5] && f[0]);
  endfunction : in_slot

  // Clocks since reset release; tick minus one is the cycle position behind pwm_o
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tick <= 14'h0000;
    end else begin
      tick <= tick + 14'h0001;
    end
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
      bad_count++;
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  // One bus cycle, entered at a falling edge; a read notes its expected data
  task automatic op(input logic w, input logic r, input logic [15:0] a, input logic [7:0] d);
    wr_en_i = w;
    rd_en_i = r;
    addr_i  = a;
    wdata_i = d;
    if (r) q.push_back({8'h00, d});
    @(negedge clk_sys_i);
  endtask : op

  // Program the multiplier and, with both set, the coarse value, let it load, then count high clocks over one whole frame;
  // any frame-long window works, so the count does not depend on phase
  task automatic run(input logic [7:0] m, input logic [5:0] n, input logic both);
    logic [15:0] c;
    logic [15:0] ne;
    logic [13:0] p;
    op(1'b1, 1'b0, RATE_MULT_ADDR, {2'b00, n});
    if (both) op(1'b1, 1'b0, COARSE_DUTY_ADDR, m);
    op(1'b0, 1'b0, 16'h0000, 8'h00);
    if (both) duty = {2'b00, m, n};
    q.push_back(duty);
    repeat (600) @(negedge clk_sys_i);
    c = 16'h0000;
    ne = 16'h0000;
    // Per clock: coarse high below M, fine pulse on the last clock of an owned cycle
    repeat (16384) begin
      @(negedge clk_sys_i);
      c = c + {15'h0000, pwm_o};
      p = tick - 14'h0001;
      if (pwm_o !== ((p[7:0] < duty[13:6]) || (p[7:0] == 8'hFF && in_slot(duty[5:0], p[13:8])))) begin
        ne = ne + 16'h0001;
      end
    end
    chk("duty", q.pop_front(), c);
    chk("pattern", 16'h0000, ne);
    $display("test duty %0h done", duty);
  endtask : run

  // Read monitor: oldest note against settled read data
  always @(posedge clk_sys_i) begin
    if (rd_en_i === 1'b1) begin
      #1;
      chk("rdata", q.pop_front(), {8'h00, rdata_o});
    end
  end

  initial begin
    {wr_en_i, rd_en_i, addr_i, wdata_i} = '0;
    rstn_i = 1'b0;
    duty = 16'h0000;
    seed = 32'h0916F82D;
    repeat (5) @(negedge clk_sys_i);
    rstn_i = 1'b1;
    chk("oe", 16'h0001, {15'h0000, pwm_pad_oe_o});
    op(1'b0, 1'b1, RATE_MULT_ADDR, 8'h00);
    op(1'b0, 1'b1, COARSE_DUTY_ADDR, 8'h00);
    seed = lfsr(seed);
    op(1'b1, 1'b0, RATE_MULT_ADDR, 8'hFF);
    op(1'b0, 1'b1, RATE_MULT_ADDR, 8'h3F);
    op(1'b1, 1'b0, COARSE_DUTY_ADDR, seed[7:0]);
    op(1'b0, 1'b1, COARSE_DUTY_ADDR, seed[7:0]);
    op(1'b0, 1'b1, 16'h0037, 8'h00);
    op(1'b0, 1'b0, 16'h0000, 8'h00);
    $display("test registers done");
    run(8'h00, 6'h00, 1'b1);
    run(8'hFF, 6'h3F, 1'b1);
    run(8'h80, 6'h01, 1'b1);
    seed = lfsr(seed);
    run(seed[7:0], seed[13:8], 1'b1);
    run(seed[7:0], ~seed[13:8], 1'b0);
    // Mid-run reset must clear both registers that were just written
    op(1'b1, 1'b0, RATE_MULT_ADDR, 8'h15);
    op(1'b1, 1'b0, COARSE_DUTY_ADDR, 8'hA5);
    op(1'b0, 1'b0, 16'h0000, 8'h00);
    rstn_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    rstn_i = 1'b1;
    op(1'b0, 1'b1, RATE_MULT_ADDR, 8'h00);
    op(1'b0, 1'b1, COARSE_DUTY_ADDR, 8'h00);
    op(1'b0, 1'b0, 16'h0000, 8'h00);
    $display("test reset done");
    conclude();
  end

  // Watchdog: five frames plus setup come to about 85000 clocks
  initial begin
    #(25 * 95000);
    bad_count++;
    conclude();
  end
endmodule : fourteen_bit_pwm_rate_mult_tb
